// ---- bench/host_bus_model.sv ----
// Host processor model driving the channel's parallel register bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
	input wire logic i_clk,
	input wire logic [7:0] i_dev_data,
	input wire logic i_dev_oe,
	output logic o_cs_n,
	output logic o_ior_n,
	output logic o_iow_n,
	output logic [2:0] o_addr,
	output logic [7:0] o_bus
);
	logic cs_n = 1'b1;
	logic ior_n = 1'b1;
	logic iow_n = 1'b1;
	logic drive = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] last = 8'h00;
	assign o_cs_n = cs_n;
	assign o_ior_n = ior_n;
	assign o_iow_n = iow_n;
	assign o_addr = addr;
	// Released bus keeps changing, so a stale value never reads as good
	assign o_bus = i_dev_oe ? i_dev_data : (drive ? wdata : ~last);
	always_ff @(posedge i_clk) begin
		last <= o_bus;
	end
	// Strobe low 6 cycles, answer taken at last low edge, then 8 idle
	task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		cs_n <= 1'b0;
		addr <= a;
		wdata <= d;
		drive <= wr;
		iow_n <= !wr;
		ior_n <= wr;
		repeat (6) @(posedge i_clk);
		q = o_bus;
		cs_n <= 1'b1;
		iow_n <= 1'b1;
		ior_n <= 1'b1;
		drive <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask
endmodule // host_bus_model
`default_nettype wire

// ---- bench/test_uart_efc_regs.sv ----
// Register-level testbench of the enhanced feature and threshold logic
`timescale 1ns/100ps
`default_nettype none
module test_uart_efc_regs;
	import uart_efc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic cts_n = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_char = 8'h00;
	logic [7:0] xoff2 = 8'h13;
	logic [6:0] rx_fill = 7'h00;
	logic [6:0] tx_free = 7'h00;
	logic rx_to = 1'b0;
	logic [3:0] peer_rx = 4'hb;
	logic [3:0] peer_tx = 4'h5;
	wire logic cs_n, ior_n, iow_n, oe, rts_n, tx_halt, rx_rdy, tx_rdy, special, sleep;
	wire logic [2:0] addr;
	wire logic [7:0] bus, dout, interrupt_enable_reg, modem_control_reg;
	wire logic [6:0] rx_trig, tx_trig;
	wire logic [15:0] divisor;
	wire logic [3:0] sw_mode;
	int num_errors = 0;
	int samples_checked = 0;
	logic [7:0] q;
	logic [6:0] fills [5] = '{7'h00, 7'h14, 7'h20, 7'h14, 7'h08};
	logic [6:0] rf [4] = '{7'h15, 7'h14, 7'h14, 7'h00};
	logic [6:0] tf [4] = '{7'h0c, 7'h0b, 7'h0b, 7'h40};
	always #4 i_clk = ~i_clk;
	host_bus_model host (.i_clk(i_clk), .i_dev_data(dout), .i_dev_oe(oe), .o_cs_n(cs_n),
		.o_ior_n(ior_n), .o_iow_n(iow_n), .o_addr(addr), .o_bus(bus));
	uart_efc_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_ior_n(ior_n),
		.i_iow_n(iow_n), .i_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe(oe),
		.i_cts_n(cts_n), .o_rts_n(rts_n), .o_tx_halt(tx_halt), .i_rx_char_valid(rx_valid),
		.i_rx_char(rx_char), .i_xoff2_char(xoff2), .i_rx_fill(rx_fill), .i_tx_free(tx_free),
		.i_rx_timeout(rx_to), .i_peer_rx_ready(peer_rx), .i_peer_tx_ready(peer_tx),
		.o_rx_ready(rx_rdy), .o_tx_ready(tx_rdy), .o_rx_trigger(rx_trig),
		.o_tx_trigger(tx_trig), .o_divisor(divisor), .o_sw_flow_mode(sw_mode),
		.o_special_irq(special), .o_sleep_en(sleep), .o_ier(interrupt_enable_reg), .o_fcr(), .o_mcr(modem_control_reg),
		.o_lcr());
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		host.access(1'b0, a, 8'h00, q);
		chk("read data", 16'(exp), 16'(q));
	endtask
	task automatic settle;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic rx_send(input logic [7:0] c);
		@(posedge i_clk);
		rx_char <= c;
		rx_valid <= 1'b1;
		@(posedge i_clk);
		rx_valid <= 1'b0;
		settle;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("rts_n", 16'h0001, 16'(rts_n));
		rd(ADDR_LCR, 8'h00);
		wr(ADDR_LCR, 8'h80);
		wr(ADDR_DIV_LOW, 8'h34);
		wr(ADDR_DIV_HIGH, 8'h12);
		chk("divisor", 16'h1234, divisor);
		wr(ADDR_LCR, 8'h00);
		wr(ADDR_IER, 8'hff);
		chk("ier", 16'h000f, 16'(interrupt_enable_reg));
		wr(ADDR_MCR, 8'he4);
		chk("mcr", 16'h0004, 16'(modem_control_reg));
		wr(ADDR_LCR, LCR_EFR_KEY);
		wr(ADDR_EFR, 8'h1b);
		chk("sw mode", 16'h000b, 16'(sw_mode));
		wr(ADDR_LCR, 8'h00);
		wr(ADDR_IER, 8'he0);
		chk("ier", 16'h00e0, 16'(interrupt_enable_reg));
		wr(ADDR_EFR, 8'h21);
		wr(ADDR_TRIG, 8'h53);
		chk("rx trigger", 16'(FCR_RX_LEVELS[0]), 16'(rx_trig));
		wr(ADDR_MCR, 8'h44);
		wr(ADDR_FLOW, 8'h28);
		wr(ADDR_TRIG, 8'h53);
		chk("rx trigger", 16'h0014, 16'(rx_trig));
		chk("tx trigger", 16'h000c, 16'(tx_trig));
		wr(ADDR_TRIG, 8'h50);
		chk("tx trigger", 16'(FCR_TX_LEVELS[2]), 16'(tx_trig));
		wr(ADDR_TRIG, 8'h53);
		wr(ADDR_MCR, 8'h04);
		wr(ADDR_FLOW, 8'h11);
		wr(ADDR_LCR, LCR_EFR_KEY);
		wr(ADDR_EFR, 8'hfb);
		wr(ADDR_LCR, 8'h00);
		// Rise to halt, hold through the band, fall at resume
		foreach (fills[i]) begin
			rx_fill <= fills[i];
			settle;
			chk("rts_n", 16'((i == 2) || (i == 3)), 16'(rts_n));
		end
		cts_n <= 1'b1;
		settle;
		chk("tx halt", 16'h0001, 16'(tx_halt));
		cts_n <= 1'b0;
		settle;
		chk("tx halt", 16'h0000, 16'(tx_halt));
		rx_send(8'h11);
		chk("special", 16'h0000, 16'(special));
		rx_send(8'h13);
		chk("special", 16'h0001, 16'(special));
		rd(ADDR_EFR, 8'hd0);
		chk("special", 16'h0000, 16'(special));
		foreach (rf[i]) begin
			rx_fill <= rf[i];
			tx_free <= tf[i];
			rx_to <= (i == 2);
			settle;
			chk("rx ready", 16'(i[0] == 1'b0), 16'(rx_rdy));
			chk("tx ready", 16'(i == 0 || i == 3), 16'(tx_rdy));
			rd(ADDR_TRIG, {3'b101, !i[0], 3'b010, (i == 0 || i == 3)});
		end
		wr(ADDR_MCR, 8'h14);
		rd(ADDR_TRIG, 8'h00);
		wr(ADDR_IER, 8'hf0);
		chk("sleep", 16'h0001, 16'(sleep));
		wr(ADDR_LCR, 8'h80);
		wr(ADDR_DIV_LOW, 8'h55);
		chk("divisor", 16'h1234, divisor);
		report_and_stop;
	end
endmodule // test_uart_efc_regs
`default_nettype wire

// ---- rtl/flow_levels.sv ----
// Threshold resolution, RTS hysteresis and FIFO-ready comparison for one channel
`timescale 1ns/100ps
`default_nettype none
module flow_levels
	import uart_efc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_flow_reg,
	input wire logic [7:0] i_trig_reg,
	input wire logic [7:0] i_fcr,
	input wire logic i_rts_en,
	input wire logic [6:0] i_rx_fill,
	input wire logic [6:0] i_tx_free,
	input wire logic i_rx_timeout,
	output logic [6:0] o_rx_trig,
	output logic [6:0] o_tx_trig,
	output logic [6:0] o_halt_level,
	output logic [6:0] o_resume_level,
	output logic o_halted,
	output logic o_rx_ready,
	output logic o_tx_ready
);

	// Halt in low nibble, resume in high nibble
	assign o_halt_level = nibble_level(i_flow_reg[3:0]); // [RULE8]
	assign o_resume_level = nibble_level(i_flow_reg[7:4]); // [RULE8]

	// Zero nibble falls back to the FIFO control selection
	always_comb begin
		if (i_trig_reg[7:4] == 4'h0) begin
			o_rx_trig = FCR_RX_LEVELS[i_fcr[FCR_RX_SEL_LSB +: 2]]; // [RULE13]
		end else begin
			o_rx_trig = nibble_level(i_trig_reg[7:4]); // [RULE11]
		end
		if (i_trig_reg[3:0] == 4'h0) begin
			o_tx_trig = FCR_TX_LEVELS[i_fcr[FCR_TX_SEL_LSB +: 2]]; // [RULE13]
		end else begin
			o_tx_trig = nibble_level(i_trig_reg[3:0]); // [RULE11]
		end
	end

	assign o_rx_ready = (i_rx_fill > o_rx_trig) || i_rx_timeout; // [RULE14]
	assign o_tx_ready = i_tx_free >= o_tx_trig; // [RULE15]

	// No ordering check on halt and resume; host keeps halt above resume
	always_ff @(posedge i_clk) begin // [RULE10]
		if (!i_rst_n) begin
			o_halted <= 1'b0;
		end else if (!i_rts_en) begin
			o_halted <= 1'b0;
		end else if (i_rx_fill >= o_halt_level) begin
			o_halted <= 1'b1; // [RULE2]
		end else if (i_rx_fill <= o_resume_level) begin
			o_halted <= 1'b0; // [RULE2]
		end
	end

endmodule // flow_levels
`default_nettype wire

// ---- rtl/uart_efc_pkg.sv ----
// Constants shared by the enhanced feature, divisor and threshold register logic
package uart_efc_pkg;

	// Register addresses on the 3-bit host address bus
	localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
	localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_EFR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_FLOW = 3'h6;
	localparam logic [2:0] ADDR_TRIG = 3'h7;

	// Line control value that opens the enhanced feature register
	localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
	localparam int LCR_DIV_BIT = 7;

	// Enhanced feature control bits
	localparam int EFR_CTS_BIT = 7;
	localparam int EFR_RTS_BIT = 6;
	localparam int EFR_SPECIAL_BIT = 5;
	localparam int EFR_ENH_BIT = 4;

	localparam int IER_SLEEP_BIT = 4;
	localparam int FCR_ENABLE_BIT = 0;
	localparam int FCR_TX_SEL_LSB = 4;
	localparam int FCR_RX_SEL_LSB = 6;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_RDY_EN_BIT = 2;
	localparam int MCR_LOOP_BIT = 4;
	localparam int MCR_EXT_BIT = 6;

	// Bits that only change while enhanced functions are enabled
	localparam logic [7:0] IER_ENH_MASK = 8'hf0;
	localparam logic [7:0] FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] MCR_ENH_MASK = 8'he0;

	localparam logic [7:0] REG_RESET = 8'h00;

	// Trigger levels selected through the FIFO control register
	localparam logic [3:0][6:0] FCR_RX_LEVELS = {7'h3c, 7'h38, 7'h10, 7'h08};
	localparam logic [3:0][6:0] FCR_TX_LEVELS = {7'h38, 7'h20, 7'h10, 7'h08};

	// Position of this channel in the shared FIFO-ready register
	localparam logic [1:0] OWN_CHANNEL = 2'h0;

	// Nibble to FIFO level in steps of four
	function automatic logic [6:0] nibble_level(input logic [3:0] nib);
		return {1'b0, nib, 2'b00};
	endfunction

endpackage

// ---- rtl/uart_efc_regs.sv ----
// Enhanced feature, divisor and threshold registers of one UART channel
//
// Function
// [RULE1] CTS high halts transmitter when enabled
// [RULE2] RTS high at halt level, low at resume
// [RULE3] Match second Xoff character, flag special event
// [RULE4] Enhanced bit gates protected register bit writes
// [RULE5] Low four bits select software flow mode
// [RULE6] Divisor is high latch over low latch
// [RULE7] Host writes divisor before enabling sleep
// [RULE8] Threshold nibbles give resume and halt levels
// [RULE9] Threshold writes need enhanced and modem bit6
// [RULE10] Host orders halt above resume; unchecked
// [RULE11] Trigger nibbles give receive and transmit levels
// [RULE12] Trigger writes need enhanced and modem bit6
// [RULE13] Zero trigger nibble uses FIFO control level
// [RULE14] Upper ready bits: receive above trigger, timeout
// [RULE15] Lower ready bits: transmit space at trigger
// [RULE16] Ready register at address seven when enabled
// [RULE17] Interrupt ident bit four shows special event
// [RULE18] Channel A lowest bit, D highest bit
`timescale 1ns/100ps
`default_nettype none
module uart_efc_regs
	import uart_efc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_ior_n,
	input wire logic i_iow_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	input wire logic i_cts_n,
	output logic o_rts_n,
	output logic o_tx_halt,
	input wire logic i_rx_char_valid,
	input wire logic [7:0] i_rx_char,
	input wire logic [7:0] i_xoff2_char,
	input wire logic [6:0] i_rx_fill,
	input wire logic [6:0] i_tx_free,
	input wire logic i_rx_timeout,
	input wire logic [3:0] i_peer_rx_ready,
	input wire logic [3:0] i_peer_tx_ready,
	output logic o_rx_ready,
	output logic o_tx_ready,
	output logic [6:0] o_rx_trigger,
	output logic [6:0] o_tx_trigger,
	output logic [15:0] o_divisor,
	output logic [3:0] o_sw_flow_mode,
	output logic o_special_irq,
	output logic o_sleep_en,
	output logic [7:0] o_ier,
	output logic [7:0] o_fcr,
	output logic [7:0] o_mcr,
	output logic [7:0] o_lcr
);

	logic cs_s1, cs_s2, ior_s1, ior_s2, iow_s1, iow_s2;
	logic cts_s1, cts_s2;
	logic [2:0] addr_s1, addr_s2, addr_lat;
	logic [7:0] data_s1, data_s2, data_lat;
	logic cs_prev, ior_prev, iow_prev;
	logic wr_fire, rd_fire;
	logic [7:0] div_low, div_high, interrupt_enable_reg, fifo_control_reg, lcr, modem_control_reg, enhanced_feature_control, flow_reg, trig_reg;
	logic special_flag, special_hit;
	logic div_sel, efr_sel, ext_sel, rdy_sel;
	logic [7:0] interrupt_ident_reg, fifo_rdy, next_rd_data;
	logic [6:0] rx_trig, tx_trig, halt_level, resume_level;
	logic halted, rx_rdy, tx_rdy;

	// Write honours a protected mask only while enhanced functions are off
	function automatic logic [7:0] masked_write(input logic [7:0] old_val,
		input logic [7:0] new_val, input logic [7:0] mask, input logic enh);
		if (enh) begin
			return new_val;
		end
		return (old_val & mask) | (new_val & ~mask);
	endfunction

	// Insert this channel's bit into a four-channel nibble, A lowest
	function automatic logic [3:0] place_own(input logic [3:0] peers, input logic own);
		logic [3:0] res;
		res = peers;
		res[OWN_CHANNEL] = own; // [RULE18]
		return res;
	endfunction

	// Host bus and CTS pin synchronisers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			ior_s1 <= 1'b1;
			ior_s2 <= 1'b1;
			iow_s1 <= 1'b1;
			iow_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
			addr_s1 <= 3'h0;
			addr_s2 <= 3'h0;
			data_s1 <= 8'h00;
			data_s2 <= 8'h00;
		end else begin
			cs_s1 <= i_cs_n;
			cs_s2 <= cs_s1;
			ior_s1 <= i_ior_n;
			ior_s2 <= ior_s1;
			iow_s1 <= i_iow_n;
			iow_s2 <= iow_s1;
			cts_s1 <= i_cts_n;
			cts_s2 <= cts_s1;
			addr_s1 <= i_addr;
			addr_s2 <= addr_s1;
			data_s1 <= i_data;
			data_s2 <= data_s1;
		end
	end

	// Address and data held while a strobe is low; acted on at its end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cs_prev <= 1'b1;
			ior_prev <= 1'b1;
			iow_prev <= 1'b1;
			addr_lat <= 3'h0;
			data_lat <= 8'h00;
		end else begin
			cs_prev <= cs_s2;
			ior_prev <= ior_s2;
			iow_prev <= iow_s2;
			if (!cs_s2 && (!iow_s2 || !ior_s2)) begin
				addr_lat <= addr_s2;
				data_lat <= data_s2;
			end
		end
	end

	assign wr_fire = !iow_prev && iow_s2 && !cs_prev;
	assign rd_fire = !ior_prev && ior_s2 && !cs_prev;

	assign div_sel = lcr[LCR_DIV_BIT];
	assign efr_sel = lcr == LCR_EFR_KEY;
	assign ext_sel = enhanced_feature_control[EFR_ENH_BIT] && modem_control_reg[MCR_EXT_BIT] && !div_sel; // [RULE9] [RULE12]
	assign rdy_sel = modem_control_reg[MCR_RDY_EN_BIT] && !modem_control_reg[MCR_LOOP_BIT]; // [RULE16]

	// Divisor latches, frozen once sleep is enabled
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			div_low <= REG_RESET;
			div_high <= REG_RESET;
		end else if (wr_fire && div_sel && !interrupt_enable_reg[IER_SLEEP_BIT]) begin // [RULE7]
			if (addr_lat == ADDR_DIV_LOW) begin
				div_low <= data_lat;
			end
			if (addr_lat == ADDR_DIV_HIGH) begin
				div_high <= data_lat;
			end
		end
	end

	// Base registers with enhanced-protected bits
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			interrupt_enable_reg <= REG_RESET;
			fifo_control_reg <= REG_RESET;
			lcr <= REG_RESET;
			modem_control_reg <= REG_RESET;
			enhanced_feature_control <= REG_RESET;
		end else if (wr_fire) begin
			unique case (addr_lat)
				ADDR_IER: begin
					if (!div_sel) begin
						interrupt_enable_reg <= masked_write(interrupt_enable_reg, data_lat, IER_ENH_MASK, enhanced_feature_control[EFR_ENH_BIT]); // [RULE4]
					end
				end
				ADDR_EFR: begin
					if (efr_sel) begin
						enhanced_feature_control <= data_lat;
					end else begin
						fifo_control_reg <= masked_write(fifo_control_reg, data_lat, FCR_ENH_MASK, enhanced_feature_control[EFR_ENH_BIT]); // [RULE4]
					end
				end
				ADDR_LCR: begin
					lcr <= data_lat;
				end
				ADDR_MCR: begin
					modem_control_reg <= masked_write(modem_control_reg, data_lat, MCR_ENH_MASK, enhanced_feature_control[EFR_ENH_BIT]); // [RULE4]
				end
				default: begin
				end
			endcase
		end
	end

	// Threshold and trigger registers behind the extended access gate
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			flow_reg <= REG_RESET;
			trig_reg <= REG_RESET;
		end else if (wr_fire && ext_sel) begin
			if (addr_lat == ADDR_FLOW) begin
				flow_reg <= data_lat; // [RULE9]
			end
			if (addr_lat == ADDR_TRIG) begin
				trig_reg <= data_lat; // [RULE12]
			end
		end
	end

	// Special character event; a new match beats the clear by ident read
	assign special_hit = enhanced_feature_control[EFR_SPECIAL_BIT] && i_rx_char_valid && (i_rx_char == i_xoff2_char);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			special_flag <= 1'b0;
		end else if (special_hit) begin
			special_flag <= 1'b1; // [RULE3]
		end else if (rd_fire && addr_lat == ADDR_EFR && !efr_sel) begin
			special_flag <= 1'b0;
		end
	end

	// Only the special source is known here; it takes the level five code
	assign interrupt_ident_reg = {fifo_control_reg[FCR_ENABLE_BIT], fifo_control_reg[FCR_ENABLE_BIT], 1'b0, special_flag, 3'h0,
		!special_flag}; // [RULE17]

	flow_levels u_levels (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flow_reg(flow_reg),
		.i_trig_reg(trig_reg),
		.i_fcr(fifo_control_reg),
		.i_rts_en(enhanced_feature_control[EFR_RTS_BIT]),
		.i_rx_fill(i_rx_fill),
		.i_tx_free(i_tx_free),
		.i_rx_timeout(i_rx_timeout),
		.o_rx_trig(rx_trig),
		.o_tx_trig(tx_trig),
		.o_halt_level(halt_level),
		.o_resume_level(resume_level),
		.o_halted(halted),
		.o_rx_ready(rx_rdy),
		.o_tx_ready(tx_rdy)
	);

	assign fifo_rdy = {place_own(i_peer_rx_ready, rx_rdy), place_own(i_peer_tx_ready, tx_rdy)}; // [RULE14] [RULE15]

	// Read data selection
	always_comb begin
		next_rd_data = 8'h00;
		unique case (addr_s2)
			ADDR_DIV_LOW: next_rd_data = div_sel ? div_low : 8'h00;
			ADDR_DIV_HIGH: next_rd_data = div_sel ? div_high : interrupt_enable_reg;
			ADDR_EFR: next_rd_data = efr_sel ? enhanced_feature_control : interrupt_ident_reg;
			ADDR_LCR: next_rd_data = lcr;
			ADDR_MCR: next_rd_data = modem_control_reg;
			ADDR_FLOW: next_rd_data = ext_sel ? flow_reg : 8'h00;
			ADDR_TRIG: begin
				if (ext_sel) begin
					next_rd_data = trig_reg;
				end else if (rdy_sel) begin
					next_rd_data = fifo_rdy; // [RULE16]
				end
			end
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
		end else begin
			o_data_oe <= !cs_s2 && !ior_s2;
			o_data <= next_rd_data;
		end
	end

	// Flow control pins
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tx_halt <= 1'b0;
			o_rts_n <= 1'b1;
		end else begin
			o_tx_halt <= enhanced_feature_control[EFR_CTS_BIT] && cts_s2; // [RULE1]
			o_rts_n <= enhanced_feature_control[EFR_RTS_BIT] ? halted : !modem_control_reg[MCR_RTS_BIT]; // [RULE2]
		end
	end

	// Registered copies toward the shifter, FIFOs and interrupt logic
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_divisor <= 16'h0000;
			o_sw_flow_mode <= 4'h0;
			o_rx_trigger <= 7'h00;
			o_tx_trigger <= 7'h00;
			o_rx_ready <= 1'b0;
			o_tx_ready <= 1'b0;
			o_special_irq <= 1'b0;
			o_sleep_en <= 1'b0;
			o_ier <= REG_RESET;
			o_fcr <= REG_RESET;
			o_mcr <= REG_RESET;
			o_lcr <= REG_RESET;
		end else begin
			o_divisor <= {div_high, div_low}; // [RULE6]
			o_sw_flow_mode <= enhanced_feature_control[3:0]; // [RULE5]
			o_rx_trigger <= rx_trig;
			o_tx_trigger <= tx_trig;
			o_rx_ready <= rx_rdy;
			o_tx_ready <= tx_rdy;
			o_special_irq <= special_flag;
			o_sleep_en <= interrupt_enable_reg[IER_SLEEP_BIT];
			o_ier <= interrupt_enable_reg;
			o_fcr <= fifo_control_reg;
			o_mcr <= modem_control_reg;
			o_lcr <= lcr;
		end
	end

	property p_cts_halt;
		@(posedge i_clk) disable iff (!i_rst_n)
		(enhanced_feature_control[EFR_CTS_BIT] && cts_s2) |=> o_tx_halt;
	endproperty
	a_cts_halt: assert property (p_cts_halt) else $error("tx not halted on cts high"); // [RULE1]

	property p_rts_halt;
		@(posedge i_clk) disable iff (!i_rst_n)
		(enhanced_feature_control[EFR_RTS_BIT] && i_rx_fill >= halt_level) ##1 enhanced_feature_control[EFR_RTS_BIT] |=> o_rts_n;
	endproperty
	a_rts_halt: assert property (p_rts_halt) else $error("rts not raised at halt level"); // [RULE2]

	property p_rts_resume;
		@(posedge i_clk) disable iff (!i_rst_n)
		(enhanced_feature_control[EFR_RTS_BIT] && i_rx_fill <= resume_level && i_rx_fill < halt_level)
			##1 enhanced_feature_control[EFR_RTS_BIT] |=> !o_rts_n;
	endproperty
	a_rts_resume: assert property (p_rts_resume) else $error("rts not lowered at resume"); // [RULE2]

	property p_special_set;
		@(posedge i_clk) disable iff (!i_rst_n)
		special_hit |=> special_flag ##1 o_special_irq;
	endproperty
	a_special_set: assert property (p_special_set) else $error("special match not flagged"); // [RULE3]

	property p_ier_protect;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && addr_lat == ADDR_IER && !div_sel && !enhanced_feature_control[EFR_ENH_BIT])
			|=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4]);
	endproperty
	a_ier_protect: assert property (p_ier_protect) else $error("protected ier bits changed"); // [RULE4]

	property p_div_high;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && addr_lat == ADDR_DIV_HIGH && div_sel && !interrupt_enable_reg[IER_SLEEP_BIT])
			|=> ##1 o_divisor[15:8] == $past(data_lat, 2);
	endproperty
	a_div_high: assert property (p_div_high) else $error("divisor high byte wrong"); // [RULE6]

	property p_div_sleep;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && interrupt_enable_reg[IER_SLEEP_BIT]) |=> $stable(div_low) && $stable(div_high);
	endproperty
	a_div_sleep: assert property (p_div_sleep) else $error("divisor written in sleep"); // [RULE7]

	property p_flow_guard;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && addr_lat == ADDR_FLOW && !(enhanced_feature_control[EFR_ENH_BIT] && modem_control_reg[MCR_EXT_BIT]))
			|=> $stable(flow_reg);
	endproperty
	a_flow_guard: assert property (p_flow_guard) else $error("threshold write not blocked"); // [RULE9]

	property p_trig_guard;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && addr_lat == ADDR_TRIG && !(enhanced_feature_control[EFR_ENH_BIT] && modem_control_reg[MCR_EXT_BIT]))
			|=> $stable(trig_reg);
	endproperty
	a_trig_guard: assert property (p_trig_guard) else $error("trigger write not blocked"); // [RULE12]

	property p_trig_fallback;
		@(posedge i_clk) disable iff (!i_rst_n)
		(trig_reg[7:4] == 4'h0) |=> o_rx_trigger == FCR_RX_LEVELS[$past(fifo_control_reg[7:6])];
	endproperty
	a_trig_fallback: assert property (p_trig_fallback) else $error("rx trigger fallback wrong"); // [RULE13]

	property p_rx_ready;
		@(posedge i_clk) disable iff (!i_rst_n)
		1'b1 |=> o_rx_ready == ($past(i_rx_fill) > $past(rx_trig) || $past(i_rx_timeout));
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("rx ready wrong"); // [RULE14]

	property p_tx_ready;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_tx_free < tx_trig) |=> !o_tx_ready;
	endproperty
	a_tx_ready: assert property (p_tx_ready) else $error("tx ready set without space"); // [RULE15]

	property p_rdy_read;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!cs_s2 && !ior_s2 && addr_s2 == ADDR_TRIG && !ext_sel && rdy_sel)
			|=> o_data_oe && o_data == $past(fifo_rdy);
	endproperty
	a_rdy_read: assert property (p_rdy_read) else $error("fifo ready read wrong"); // [RULE16]

	property p_iir_bit;
		@(posedge i_clk) disable iff (!i_rst_n)
		(special_flag && !cs_s2 && !ior_s2 && addr_s2 == ADDR_EFR && !efr_sel)
			|=> o_data[4] && !o_data[0];
	endproperty
	a_iir_bit: assert property (p_iir_bit) else $error("ident bit four not shown"); // [RULE17]

endmodule // uart_efc_regs
`default_nettype wire
